/* File: hw/status_dump_mem.sv */
// Word store for the extended status dump, registered read port
`timescale 1ns/100ps
`include "tape_cfg.svh"
module status_dump_mem #(
  parameter int W  = 16,
  parameter int AW = `DUMP_AW
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // status_dump_mem

/* File: hw/tape_cfg.svh */
// Offsets, field positions, status codes and sizes of the transfer block
`ifndef TAPE_CFG_SVH
`define TAPE_CFG_SVH

`define WIN_FIRST        11'h400
`define WIN_LAST         11'h7fc
`define UNIT_WIN_BYTES   128
`define OFS_CMD          7'h00
`define OFS_STAT         7'h04

`define CMD_GO_BIT       0
`define FUNC_MSB         5
`define FUNC_LSB         1
`define STAT_FAIL_MSB    15
`define STAT_FAIL_LSB    10
`define STAT_PRESENT_BIT 8
`define STAT_INTR_MSB    5

`define CMD_WRITE_PE     6'h31
`define CMD_WRITE_GCR    6'h33
`define CMD_READ_FWD     6'h39
`define CMD_READ_REV     6'h3f
`define CMD_CHECK_FWD    6'h29
`define CMD_CHECK_REV    6'h2f
`define CMD_SENSE        6'h3b

`define INT_DONE         6'h01
`define INT_TAPE_MARK    6'h02
`define INT_BOT          6'h03
`define INT_EOT          6'h04
`define INT_WRITE_LOCK   6'h08
`define INT_REWIND_LOAD  6'h09
`define INT_FATAL        6'h0a
`define INT_BUSY         6'h0b
`define INT_NOT_AVAIL    6'h0c
`define INT_OFF_LINE     6'h0d
`define INT_NO_XPORT     6'h0e
`define INT_NOT_CAPABLE  6'h0f
`define INT_ECC          6'h12

`define FAIL_NONE        6'h00
`define FAIL_SENSE_NEW   6'h01
`define FAIL_BOT_ISSUE   6'h01
`define FAIL_BOT_MOTION  6'h02
`define FAIL_BOT_ARA     6'h03
`define FAIL_REWIND      6'h01
`define FAIL_FATAL       6'h02
`define FAIL_BUSY        6'h03
`define FAIL_NOT_AVAIL   6'h01
`define FAIL_OFF_LINE    6'h02
`define FAIL_NO_XPORT    6'h03

`define DUMP_BYTES       60
`define DUMP_WORDS       30
`define DUMP_AW          5

`endif

/* File: hw/tape_pkg.sv */
// Types shared by the transfer command block
package tape_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_RUN    = 3'b010,
    ST_DUMP   = 3'b011,
    ST_FINISH = 3'b100
  } xfer_state_e;
  typedef logic [5:0] code_t;
endpackage

/* File: hw/tape_transfer_command_status.sv */
// Transfer command interpreter and completion status of a tape formatter
`timescale 1ns/100ps
`include "tape_cfg.svh"
module tape_transfer_command_status
  import tape_pkg::*;
#(
  parameter int DUMP_WORDS = `DUMP_WORDS
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [10:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_ack,
  input  wire logic [2:0]  unit_plug,
  input  wire logic        formatter_present,
  input  wire logic        tape_at_bot,
  input  wire logic        tape_past_eot,
  input  wire logic        write_locked,
  input  wire logic        xport_rewinding,
  input  wire logic        xport_loading,
  input  wire logic        xport_busy_other,
  input  wire logic        xport_available,
  input  wire logic        xport_online,
  input  wire logic        xport_exists,
  input  wire logic        fatal_detect,
  input  wire logic        formatter_clear_bit,
  input  wire logic        op_finish,
  input  wire logic        tape_mark_hit,
  input  wire logic        ara_id_seen,
  input  wire logic [1:0]  not_capable_reason,
  input  wire logic [1:0]  ecc_fault,
  input  wire logic        sense_wr,
  input  wire logic [4:0]  sense_addr,
  input  wire logic [15:0] sense_data,
  output logic             op_start,
  output logic [4:0]       op_func,
  output logic             op_reverse,
  output logic             pe_mode,
  output logic             dump_valid,
  output logic [15:0]      dump_word
);
  localparam int NS = 22;

  // Two-stage synchroniser for the plug and tape status inputs, not the bus or sense-store inputs
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  logic [1:0]    edge_prev;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {unit_plug, formatter_present, tape_at_bot, tape_past_eot,
                write_locked, xport_rewinding, xport_loading,
                xport_busy_other, xport_available, xport_online,
                xport_exists, fatal_detect, formatter_clear_bit, op_finish,
                tape_mark_hit, ara_id_seen, not_capable_reason, ecc_fault};
      sync2 <= sync1;
    end
  end

  wire [2:0] plug_s      = sync2[21:19];
  wire       present_s   = sync2[18];
  wire       bot_s       = sync2[17];
  wire       eot_s       = sync2[16];
  wire       wlock_s     = sync2[15];
  wire       rewind_s    = sync2[14];
  wire       loading_s   = sync2[13];
  wire       busy_s      = sync2[12];
  wire       avail_s     = sync2[11];
  wire       online_s    = sync2[10];
  wire       exists_s    = sync2[9];
  wire       fatal_s     = sync2[8];
  wire       fclear_s    = sync2[7];
  wire       finish_s    = sync2[6];
  wire       tmark_s     = sync2[5];
  wire       ara_s       = sync2[4];
  wire [1:0] notcap_s    = sync2[3:2];
  wire [1:0] ecc_s       = sync2[1:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_prev <= '0;
    end else begin
      edge_prev <= {fatal_s, finish_s};
    end
  end
  wire finish_pulse = finish_s & ~edge_prev[0];
  wire fatal_pulse  = fatal_s & ~edge_prev[1];

  function automatic logic is_write(input code_t c);
    return (c == `CMD_WRITE_PE) || (c == `CMD_WRITE_GCR);
  endfunction
  function automatic logic is_known(input code_t c);
    return is_write(c) || (c == `CMD_READ_FWD) || (c == `CMD_READ_REV) ||
           (c == `CMD_CHECK_FWD) || (c == `CMD_CHECK_REV) ||
           (c == `CMD_SENSE);
  endfunction
  function automatic logic is_reverse(input code_t c);
    return (c == `CMD_READ_REV) || (c == `CMD_CHECK_REV);
  endfunction

  // Window decode: upper half of the adapter space, unit field = plug
  wire in_space  = (reg_addr >= `WIN_FIRST) &&
                   (reg_addr <= `WIN_LAST + 11'h003);
  wire in_unit   = in_space && (reg_addr[9:7] == plug_s);
  wire hit_cmd   = in_unit && (reg_addr[6:2] == 5'(`OFS_CMD >> 2));
  wire hit_stat  = in_unit && (reg_addr[6:2] == 5'(`OFS_STAT >> 2));

  xfer_state_e state;
  xfer_state_e next_state;
  logic        go;
  code_t       cmd;
  code_t       intr_code;
  code_t       fail_code;
  logic        fatal_hold;
  logic        sense_new;
  logic        bot_at_issue;
  logic [4:0]  dump_idx;
  wire cmd_write = reg_wr && hit_cmd && !go && reg_wdata[`CMD_GO_BIT];
  // Refusal decode, highest priority first
  wire   refuse_fatal  = fatal_hold;
  wire   refuse_rewld  = rewind_s || loading_s;
  wire   refuse_busy   = busy_s;
  wire   refuse_wlock  = is_write(cmd) && wlock_s;
  wire   refuse_any    = refuse_fatal || !exists_s || !online_s ||
                         !avail_s || refuse_rewld || refuse_busy ||
                         refuse_wlock;
  // Answers are packed as {interrupt code, subcode}
  wire [11:0] refuse_pair =
      refuse_fatal ? {`INT_FATAL, `FAIL_FATAL} :
      !exists_s    ? {`INT_NO_XPORT, `FAIL_NO_XPORT} :
      !online_s    ? {`INT_OFF_LINE, `FAIL_OFF_LINE} :
      !avail_s     ? {`INT_NOT_AVAIL, `FAIL_NOT_AVAIL} :
      refuse_rewld ? {`INT_REWIND_LOAD, `FAIL_REWIND} :
      refuse_busy  ? {`INT_BUSY, `FAIL_BUSY} :
                     {`INT_WRITE_LOCK, `FAIL_NONE};
  // Completion decode
  wire code_t sense_sub = sense_new ? `FAIL_SENSE_NEW : `FAIL_NONE;
  wire   rd_fwd    = (cmd == `CMD_READ_FWD);
  wire   rd_rev    = (cmd == `CMD_READ_REV);
  wire code_t bot_sub = bot_at_issue ? `FAIL_BOT_ISSUE :
                        ara_s        ? `FAIL_BOT_ARA : `FAIL_BOT_MOTION;
  wire [11:0] done_pair =
      fatal_hold          ? {`INT_FATAL, `FAIL_FATAL} :
      (notcap_s != 2'b00) ? {`INT_NOT_CAPABLE, 4'h0, notcap_s} :
      (ecc_s != 2'b00)    ? {`INT_ECC, 4'h0, ecc_s} :
      (rd_fwd && tmark_s) ? {`INT_TAPE_MARK, sense_sub} :
      (rd_rev && bot_s)   ? {`INT_BOT, bot_sub} :
      eot_s               ? {`INT_EOT, sense_sub} :
                            {`INT_DONE, sense_sub};

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (cmd_write) next_state = ST_CHECK;
      ST_CHECK: begin
        if (refuse_any || !is_known(cmd)) begin
          next_state = ST_IDLE;
        end else if (cmd == `CMD_SENSE) begin
          next_state = ST_DUMP;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_RUN:    if (finish_pulse) next_state = ST_IDLE;
      ST_DUMP:   if (dump_idx == 5'(DUMP_WORDS - 1)) next_state = ST_FINISH;
      ST_FINISH: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  wire launch    = (state == ST_CHECK) && !refuse_any && is_known(cmd);
  wire end_check = (state == ST_CHECK) && (refuse_any || !is_known(cmd));
  wire end_run   = (state == ST_RUN) && finish_pulse;
  wire end_dump  = (state == ST_FINISH);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      go  <= 1'b0;
      cmd <= '0;
    end else if (cmd_write) begin
      go  <= 1'b1;
      cmd <= {reg_wdata[`FUNC_MSB:`FUNC_LSB], 1'b1};
    end else if (end_check || end_run || end_dump) begin
      go  <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      intr_code <= '0;
      fail_code <= '0;
    end else if (end_check && refuse_any) begin
      intr_code <= refuse_pair[11:6];
      fail_code <= refuse_pair[5:0];
    end else if (end_run) begin
      intr_code <= done_pair[11:6];
      fail_code <= done_pair[5:0];
    end else if (end_dump) begin
      intr_code <= `INT_DONE;
      fail_code <= `FAIL_SENSE_NEW;
    end
  end

  // Fatal and fresh-sense flags: a setting event wins over a clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fatal_hold   <= 1'b0;
      sense_new    <= 1'b0;
      bot_at_issue <= 1'b0;
    end else begin
      fatal_hold   <= fatal_pulse || (fatal_hold && !fclear_s);
      sense_new    <= sense_wr || (sense_new && !launch);
      if (launch) begin
        bot_at_issue <= bot_s;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_start   <= 1'b0;
      op_func    <= '0;
      op_reverse <= 1'b0;
      pe_mode    <= 1'b0;
    end else begin
      op_start <= launch && (cmd != `CMD_SENSE);
      if (launch) begin
        op_func    <= cmd[`FUNC_MSB:`FUNC_LSB];
        op_reverse <= is_reverse(cmd);
        if (is_write(cmd) && bot_s) begin
          pe_mode <= (cmd == `CMD_WRITE_PE);
        end
      end
    end
  end

  // Dump walks the status store, one word per cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dump_idx   <= '0;
      dump_valid <= 1'b0;
    end else begin
      dump_valid <= (state == ST_DUMP);
      dump_idx   <= (state == ST_DUMP) ? dump_idx + 5'd1 : 5'd0;
    end
  end

  status_dump_mem #(.W(16), .AW(`DUMP_AW)) u_dump_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (sense_wr),
    .wr_addr (sense_addr),
    .wr_data (sense_data),
    .rd_addr (dump_idx),
    .rd_data (dump_word)
  );

  wire [15:0] stat_word = {fail_code, 1'b0, present_s, 2'b00, intr_code};
  wire [15:0] cmd_word  = {10'h000, cmd[5:1], go};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack   <= (reg_rd || reg_wr) && in_unit;
      reg_rdata <= !(reg_rd && in_unit) ? 16'h0000 :
                   hit_cmd  ? cmd_word :
                   hit_stat ? stat_word : 16'h0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_go_clears: assert property (end_run |=> !go)
    else $error("start bit stayed set after finish");
  chk_window_ack: assert property ((reg_rd || reg_wr) && !in_unit |=> !reg_ack)
    else $error("ack outside unit window");
  chk_present_bit: assert property (reg_rd && hit_stat |=> reg_rdata[8] == $past(present_s))
    else $error("present bit wrong");
  chk_fatal_answer: assert property (fatal_hold && state == ST_CHECK |=> intr_code == `INT_FATAL && fail_code == `FAIL_FATAL)
    else $error("fatal not reported");
  chk_wlock_refuse: assert property (state == ST_CHECK && refuse_wlock && !refuse_fatal && exists_s && online_s && avail_s && !refuse_rewld && !refuse_busy |=> intr_code == `INT_WRITE_LOCK && !op_start)
    else $error("write on locked tape not refused");
  chk_rewind_code: assert property (state == ST_CHECK && refuse_rewld && !fatal_hold && exists_s && online_s && avail_s |=> intr_code == `INT_REWIND_LOAD && fail_code == `FAIL_REWIND)
    else $error("rewind refusal code wrong");
  chk_pe_at_bot: assert property (launch && cmd == `CMD_WRITE_PE && bot_s |=> pe_mode)
    else $error("phase-encoded not selected at tape start");
  chk_mode_kept: assert property (launch && is_write(cmd) && !bot_s |=> $stable(pe_mode))
    else $error("recording mode changed away from tape start");
  chk_dump_length: assert property (launch && cmd == `CMD_SENSE |=> (state == ST_DUMP)[*1] ##30 state == ST_FINISH)
    else $error("dump length wrong");
  chk_done_code: assert property (end_run && !fatal_hold && notcap_s == 2'b00 && ecc_s == 2'b00 && !(rd_fwd && tmark_s) && !(rd_rev && bot_s) && !eot_s |=> intr_code == `INT_DONE)
    else $error("clean completion code wrong");
  chk_launch_start: assert property (launch && cmd != `CMD_SENSE |=> op_start ##1 !op_start)
    else $error("start pulse malformed");

  cov_refused: cover property (end_check && refuse_any);
  cov_run_done: cover property (end_run);
  cov_dump: cover property (end_dump);
  cov_fatal_clear: cover property (fatal_hold ##1 !fatal_hold);
endmodule // tape_transfer_command_status

/* File: testbench/host_bus_model.sv */
// Host adapter model: drives register reads and writes into the block
`timescale 1ns/100ps
module host_bus_model (
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_ack,
  output logic      [10:0] reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata
);
  initial begin
    reg_addr = 11'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One strobe cycle, then a bounded wait for the acknowledge
  task automatic xfer(input logic wr, input logic [10:0] a,
                      input logic [15:0] d, output logic ack,
                      output logic [15:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ack = 1'b0;
    q = 16'h0000;
    for (int i = 0; i < 4 && ack !== 1'b1; i++) begin
      if (reg_ack === 1'b1) begin
        ack = 1'b1;
        q = reg_rdata;
      end else begin
        @(negedge clk);
      end
    end
    // Released data lines must not keep showing the last value
    reg_wdata = ~d;
  endtask
endmodule // host_bus_model

/* File: testbench/tape_transfer_command_status_tb.sv */
// Self-checking bench for the transfer command and status block
`timescale 1ns/100ps
`include "tape_cfg.svh"
module tape_transfer_command_status_tb;
  localparam logic [10:0] base = 11'h580;
  logic        clk, rst_b, reg_wr, reg_rd, reg_ack, op_start, op_reverse;
  logic [10:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, dump_word, sense_data, q;
  logic [2:0]  unit_plug;
  logic        formatter_present, tape_at_bot, tape_past_eot, write_locked;
  logic        xport_rewinding, xport_loading, xport_busy_other;
  logic        xport_available, xport_online, xport_exists, fatal_detect;
  logic        formatter_clear_bit, op_finish, tape_mark_hit, ara_id_seen;
  logic [1:0]  not_capable_reason, ecc_fault;
  logic        sense_wr, pe_mode, dump_valid, ack, last_rev;
  logic [4:0]  sense_addr, op_func, last_func;
  logic [15:0] dump_q[$];
  logic [15:0] ref_st[7];
  int          bad_count, n_tests, start_cnt;

  tape_transfer_command_status tape_transfer_command_status_inst (
    .clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_ack, .unit_plug, .formatter_present, .tape_at_bot, .tape_past_eot,
    .write_locked, .xport_rewinding, .xport_loading, .xport_busy_other,
    .xport_available, .xport_online, .xport_exists, .fatal_detect,
    .formatter_clear_bit, .op_finish, .tape_mark_hit, .ara_id_seen,
    .not_capable_reason, .ecc_fault, .sense_wr, .sense_addr, .sense_data,
    .op_start, .op_func, .op_reverse, .pe_mode, .dump_valid, .dump_word
  );
  host_bus_model host_bus_model_inst (
    .clk, .reg_rdata, .reg_ack, .reg_addr, .reg_wr, .reg_rd, .reg_wdata
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      start_cnt <= start_cnt + 1;
      last_func <= op_func;
      last_rev <= op_reverse;
    end
    if (dump_valid === 1'b1) begin
      dump_q.push_back(dump_word);
    end
  end

  task automatic final_report();
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rd_ack(input logic [10:0] a, input logic exp_ack);
    host_bus_model_inst.xfer(1'b0, a, 16'h0000, ack, q);
    check16("ack", {15'h0, exp_ack}, {15'h0, ack});
  endtask

  // Flags: bot reached in motion, finish pulse, launch expected, reverse
  task automatic run(input logic [5:0] code, input logic [3:0] f,
                     input logic [15:0] exp);
    int n0;
    n0 = start_cnt;
    wait_cyc(3);
    host_bus_model_inst.xfer(1'b1, base, {10'h000, code}, ack, q);
    check16("cmd ack", 16'h0001, {15'h0, ack});
    if (f[2]) begin
      tape_at_bot = tape_at_bot | f[3];
      wait_cyc(3);
      op_finish = 1'b1;
      wait_cyc(4);
      op_finish = 1'b0;
    end
    q = 16'h0001;
    for (int i = 0; i < 60 && q[0] !== 1'b0; i++) begin
      host_bus_model_inst.xfer(1'b0, base, 16'h0000, ack, q);
    end
    check16("start bit", 16'h0000, {15'h0, q[0]});
    check16("launches", {15'h0, f[1]}, 16'(start_cnt - n0));
    if (f[1]) begin
      check16("func", {11'h0, code[5:1]}, {11'h0, last_func});
      check16("reverse", {15'h0, f[0]}, {15'h0, last_rev});
    end
    host_bus_model_inst.xfer(1'b0, base + 11'h004, 16'h0000, ack, q);
    check16("status", exp, q);
  endtask

  initial begin
    rst_b = 1'b0;
    unit_plug = 3'd3;
    {formatter_present, xport_available, xport_online, xport_exists} = 4'hf;
    {tape_at_bot, tape_past_eot, write_locked, xport_rewinding} = 4'h0;
    {xport_loading, xport_busy_other, fatal_detect, op_finish} = 4'h0;
    {formatter_clear_bit, tape_mark_hit, ara_id_seen, sense_wr} = 4'h0;
    not_capable_reason = 2'b00;
    ecc_fault = 2'b00;
    sense_addr = 5'h00;
    sense_data = 16'h0000;
    ref_st = '{16'h0108, 16'h0509, 16'h0509, 16'h0d0b, 16'h050c,
               16'h090d, 16'h0d0e};
    wait_cyc(5);
    rst_b = 1'b1;
    wait_cyc(3);
    host_bus_model_inst.xfer(1'b0, base + 11'h004, 16'h0000, ack, q);
    check16("reset status", 16'h0100, q);
    rd_ack(11'h400, 1'b0);
    rd_ack(11'h3fc, 1'b0);
    rd_ack(base + 11'h080, 1'b0);
    rd_ack(base, 1'b1);
    tape_at_bot = 1'b1;
    run(`CMD_WRITE_PE, 4'b0110, 16'h0101);
    check16("pe mode", 16'h0001, {15'h0, pe_mode});
    tape_at_bot = 1'b0;
    run(`CMD_WRITE_GCR, 4'b0110, 16'h0101);
    check16("pe kept", 16'h0001, {15'h0, pe_mode});
    tape_at_bot = 1'b1;
    run(`CMD_WRITE_GCR, 4'b0110, 16'h0101);
    check16("gcr mode", 16'h0000, {15'h0, pe_mode});
    run(`CMD_READ_REV, 4'b0111, 16'h0503);
    tape_at_bot = 1'b0;
    run(`CMD_READ_REV, 4'b1111, 16'h0903);
    tape_at_bot = 1'b0;
    ara_id_seen = 1'b1;
    run(`CMD_READ_REV, 4'b1111, 16'h0d03);
    {tape_at_bot, ara_id_seen} = 2'b00;
    run(`CMD_READ_FWD, 4'b0110, 16'h0101);
    run(`CMD_CHECK_FWD, 4'b0110, 16'h0101);
    run(`CMD_CHECK_REV, 4'b0111, 16'h0101);
    tape_mark_hit = 1'b1;
    run(`CMD_READ_FWD, 4'b0110, 16'h0102);
    tape_mark_hit = 1'b0;
    tape_past_eot = 1'b1;
    run(`CMD_WRITE_PE, 4'b0110, 16'h0104);
    tape_past_eot = 1'b0;
    for (int r = 1; r < 4; r++) begin
      not_capable_reason = 2'(r);
      run(`CMD_READ_FWD, 4'b0110, {6'(r), 10'h10f});
    end
    not_capable_reason = 2'b00;
    for (int r = 1; r < 4; r++) begin
      ecc_fault = 2'(r);
      run(`CMD_READ_FWD, 4'b0110, {6'(r), 10'h112});
    end
    ecc_fault = 2'b00;
    for (int k = 0; k < 7; k++) begin
      write_locked = (k == 0);
      xport_rewinding = (k == 1);
      xport_loading = (k == 2);
      xport_busy_other = (k == 3);
      xport_available = (k != 4);
      xport_online = (k != 5);
      xport_exists = (k != 6);
      run(`CMD_WRITE_PE, 4'b0000, ref_st[k]);
    end
    {xport_available, xport_online, xport_exists} = 3'b111;
    formatter_present = 1'b0;
    wait_cyc(4);
    host_bus_model_inst.xfer(1'b0, base + 11'h004, 16'h0000, ack, q);
    check16("absent", 16'h0c0e, q);
    formatter_present = 1'b1;
    fatal_detect = 1'b1;
    run(`CMD_READ_FWD, 4'b0000, 16'h090a);
    fatal_detect = 1'b0;
    run(`CMD_READ_FWD, 4'b0000, 16'h090a);
    formatter_clear_bit = 1'b1;
    wait_cyc(4);
    formatter_clear_bit = 1'b0;
    run(`CMD_READ_FWD, 4'b0110, 16'h0101);
    for (int i = 0; i < 30; i++) begin
      @(negedge clk);
      sense_wr = 1'b1;
      sense_addr = 5'(i);
      sense_data = 16'ha500 + 16'(i);
    end
    @(negedge clk);
    sense_wr = 1'b0;
    dump_q.delete();
    run(`CMD_SENSE, 4'b0000, 16'h0501);
    check16("dump words", 16'd30, 16'(dump_q.size()));
    foreach (dump_q[i]) begin
      check16("dump word", 16'ha500 + 16'(i), dump_q[i]);
    end
    // Store refreshed across the launch: completion subcode says so
    sense_wr = 1'b1;
    run(`CMD_READ_FWD, 4'b0110, 16'h0501);
    sense_wr = 1'b0;
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule // tape_transfer_command_status_tb
